// >>> adcof_top.sv
// Purpose: output formatter of a dual channel 12-bit converter with test pattern
// Assumes: converter words come from logic on ref_clk_in; mode pins are asynchronous
// Notes:   word period is WORD_DIV ref clocks, doubled in demux mode
// Function
// - ddr clock half data rate, both edges
// - ddr zero degree: data changes each edge
// - phase from pin, or bit 14 in ecm
// - no ddr when 1:2 demux selected
// - sdr clock at data rate, one edge
// - sdr edge chosen by bit 2, ecm only
// - bit 13 selects output swing
// - offset binary default, bit 4 twos complement
// - non-demux: full rate on one bus
// - demux: half rate on twice buses
// - des interleave 1:4 or undemuxed, else 1:2; here des only sets des_active_out, no 1:4 demux
// - test mode replaces converter on all outputs
// - pattern same with or without des
// - each port distinct alternating pattern word; here q and q delayed share words, as do i and i delayed
// - powered-down channel gets no pattern
// - demux five-word pattern table
// - non-demux five-word low/high pattern
`timescale 1ns/1ps
`default_nettype none
module adcof_top #(
  parameter int WORD_DIV = adcof_pkg::WORD_DIV_DEF   // ref clocks per non-demux word
) (
  input  wire logic                        ref_clk_in,          // 125 MHz block clock
  input  wire logic                        rst_n_in,            // async reset, active low
  input  wire logic                        ce_in,               // clock enable, freezes state
  input  wire logic                        ddr_phase_pin_in,    // ddr phase pin, 1 = 90 deg
  input  wire logic                        demux_select_pin_in, // 1 = demux mode
  input  wire logic                        ddr_mode_pin_in,     // 1 = ddr requested
  input  wire logic                        ecm_pin_in,          // extended_control_mode
  input  wire logic                        pd_i_pin_in,         // i channel powered down
  input  wire logic                        pd_q_pin_in,         // q channel powered down
  input  wire logic                        des_pin_in,          // dual_edge_sampling
  input  wire logic                        cfg_wr_in,           // config write strobe
  input  wire logic [adcof_pkg::ADDR_W-1:0] cfg_addr_in,        // config address
  input  wire logic [adcof_pkg::CFG_W-1:0]  cfg_wdata_in,       // config write data
  input  wire logic [adcof_pkg::DATA_W-1:0] conv_qd_in,         // converter q delayed word
  input  wire logic [adcof_pkg::DATA_W-1:0] conv_id_in,         // converter i delayed word
  input  wire logic [adcof_pkg::DATA_W-1:0] conv_q_in,          // converter q word
  input  wire logic [adcof_pkg::DATA_W-1:0] conv_i_in,          // converter i word
  input  wire logic                        conv_or_q_in,        // converter q overrange
  input  wire logic                        conv_or_i_in,        // converter i overrange
  output logic [adcof_pkg::CFG_W-1:0]       cfg_rdata_out,      // config read data
  output logic                             output_data_clock_out, // source-synchronous clock
  output logic [adcof_pkg::DATA_W-1:0]      q_delayed_bus_out,  // q delayed bus
  output logic [adcof_pkg::DATA_W-1:0]      i_delayed_bus_out,  // i delayed bus
  output logic [adcof_pkg::DATA_W-1:0]      q_bus_out,          // q bus
  output logic [adcof_pkg::DATA_W-1:0]      i_bus_out,          // i bus
  output logic                             overrange_q_out,     // q overrange
  output logic                             overrange_i_out,     // i overrange
  output logic                             swing_high_out,      // output swing select
  output logic                             word_strobe_out,     // one pulse per new word
  output logic                             des_active_out       // interleaved stream flag
);
  import adcof_pkg::*;

  // refuse word periods the clock pattern cannot serve
  // an odd period would leave the half-word point off centre
  if (WORD_DIV < 2 || WORD_DIV > 127 || (WORD_DIV % 2) != 0) begin : g_bad_div
    $error("WORD_DIV must be even and in 2..126");
  end

  // counter end points for both word periods
  localparam logic [CNT_W-1:0] DIV_N = CNT_W'(WORD_DIV);   // non-demux period
  localparam logic [CNT_W-1:0] DIV_D = CNT_W'(2 * WORD_DIV); // demux period

  // sign conversion by msb inversion
  function automatic logic [DATA_W-1:0] fmt(input logic [DATA_W-1:0] w, input logic twos);
    fmt = twos ? {~w[DATA_W-1], w[DATA_W-2:0]} : w;
  endfunction

  logic [SYNC_N-1:0] pin_raw;      // raw asynchronous pins
  logic [SYNC_N-1:0] sync1_reg;    // first sync stage
  logic [SYNC_N-1:0] sync2_reg;    // second sync stage
  logic [CFG_W-1:0]  cfg_reg;      // configuration register
  logic [CNT_W-1:0]  cnt_reg;      // position inside the word period
  logic [CNT_W-1:0]  period;       // current word period
  logic              clk_reg;      // output data clock
  logic              clk_next;     // next clock level
  logic              tp_q_reg;     // test mode seen last cycle
  logic              word_start;   // first cycle of a word
  logic              word_half;    // middle cycle of a word
  logic              extended_control_mode;          // extended control mode active
  logic              demux;        // demux mode
  logic              ddr_eff;      // ddr after mode legality
  logic              phase90;      // ddr 90 degree phase
  logic              sdr_rise;     // sdr data on rising edge
  logic              tp_en;        // test pattern mode
  logic              cfg_hit;      // config address decode
  adcof_tp_if        tp ();        // pattern carrier

  // pins gathered in the package index order
  assign pin_raw = {des_pin_in, pd_q_pin_in, pd_i_pin_in, ecm_pin_in,
                    ddr_mode_pin_in, demux_select_pin_in, ddr_phase_pin_in};

  // two-flop synchroniser per pin
  for (genvar g = 0; g < SYNC_N; g++) begin : g_sync
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        sync1_reg[g] <= 1'b0;
        sync2_reg[g] <= 1'b0;
      end else if (ce_in) begin
        sync1_reg[g] <= pin_raw[g];
        sync2_reg[g] <= sync1_reg[g];
      end
    end
  end

  // mode resolution
  assign extended_control_mode      = sync2_reg[PIN_ECM];
  assign demux    = sync2_reg[PIN_DEMUX];
  assign ddr_eff  = sync2_reg[PIN_DDR] & ~demux;
  assign phase90  = extended_control_mode ? cfg_reg[BIT_PHASE] : sync2_reg[PIN_PHASE];
  assign sdr_rise = extended_control_mode ? cfg_reg[BIT_SDR_EDGE] : 1'b1;
  assign tp_en    = cfg_reg[BIT_TP];
  assign cfg_hit  = (cfg_addr_in == CFG_ADDR);
  // demux words last twice as long
  assign period     = demux ? DIV_D : DIV_N;
  assign word_start = (cnt_reg == '0);
  assign word_half  = (cnt_reg == (period >> 1));

  // pattern generator hookup
  assign tp.restart = tp_en & ~tp_q_reg;
  assign tp.advance = tp_en & word_start;
  assign tp.demux   = demux;

  adcof_tp_gen u_gen (
    .ref_clk_in (ref_clk_in),
    .rst_n_in   (rst_n_in),
    .ce_in      (ce_in),
    .tp         (tp)
  );

  // clock level: ddr toggles per word, sdr one full cycle per word
  // sdr: start level at word start, the opposite at half word
  always_comb begin
    clk_next = clk_reg;
    if (ddr_eff) begin
      if ((word_start && !phase90) || (word_half && phase90)) begin
        clk_next = ~clk_reg;
      end
    end else if (word_start) begin
      clk_next = sdr_rise;
    end else if (word_half) begin
      clk_next = ~sdr_rise;
    end
  end

  // configuration register and read back
  // read data shows the register as it stood before a write
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cfg_reg       <= CFG_RESET;
      cfg_rdata_out <= '0;
    end else if (ce_in) begin
      if (cfg_wr_in && cfg_hit) begin
        cfg_reg <= cfg_wdata_in;
      end
      cfg_rdata_out <= cfg_hit ? cfg_reg : '0;
    end
  end

  // word timing and output clock
  // a period shortened by a mode change wraps at once
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_reg               <= '0;
      clk_reg               <= 1'b0;
      tp_q_reg              <= 1'b0;
      output_data_clock_out <= 1'b0;
    end else if (ce_in) begin
      cnt_reg               <= (cnt_reg >= period - CNT_W'(1)) ? '0 : cnt_reg + CNT_W'(1);
      clk_reg               <= clk_next;
      tp_q_reg              <= tp_en;
      output_data_clock_out <= clk_next;
    end
  end

  // data launch once per word
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q_delayed_bus_out <= '0;
      i_delayed_bus_out <= '0;
      q_bus_out         <= '0;
      i_bus_out         <= '0;
      overrange_q_out   <= 1'b0;
      overrange_i_out   <= 1'b0;
      word_strobe_out   <= 1'b0;
      swing_high_out    <= 1'b0;
      des_active_out    <= 1'b0;
    end else if (ce_in) begin
      word_strobe_out <= word_start;
      swing_high_out  <= cfg_reg[BIT_SWING];
      des_active_out  <= sync2_reg[PIN_DES];
      if (word_start && tp_en) begin
        // generator replaces the converter, dead channels stay quiet
        q_delayed_bus_out <= sync2_reg[PIN_PD_Q] ? '0 : tp.word_qd;
        q_bus_out         <= sync2_reg[PIN_PD_Q] ? '0 : tp.word_q;
        overrange_q_out   <= ~sync2_reg[PIN_PD_Q] & tp.or_q;
        i_delayed_bus_out <= sync2_reg[PIN_PD_I] ? '0 : tp.word_id;
        i_bus_out         <= sync2_reg[PIN_PD_I] ? '0 : tp.word_i;
        overrange_i_out   <= ~sync2_reg[PIN_PD_I] & tp.or_i;
      end else if (word_start) begin
        // delayed buses only carry data in demux mode
        q_delayed_bus_out <= demux ? fmt(conv_qd_in, cfg_reg[BIT_TWOS]) : '0;
        i_delayed_bus_out <= demux ? fmt(conv_id_in, cfg_reg[BIT_TWOS]) : '0;
        q_bus_out         <= fmt(conv_q_in, cfg_reg[BIT_TWOS]);
        i_bus_out         <= fmt(conv_i_in, cfg_reg[BIT_TWOS]);
        // overrange follows the converter outside test mode
        overrange_q_out   <= conv_or_q_in;
        overrange_i_out   <= conv_or_i_in;
      end
    end
  end
endmodule
`default_nettype wire

// >>> adcof_pkg.sv
// Purpose: shared constants of the output formatter and test pattern block
// Assumes: one configuration register, 16 bits wide, at address 0h
// Notes:   field positions are bit indices inside that register
package adcof_pkg;
  localparam int          DATA_W        = 12;         // sample word width
  localparam int          CFG_W         = 16;         // configuration register width
  localparam int          ADDR_W        = 4;          // configuration address width
  localparam logic [3:0]  CFG_ADDR      = 4'h0;       // configuration register address
  localparam logic [15:0] CFG_RESET     = 16'h0000;   // reset value of the register
  localparam int          BIT_PHASE     = 14;         // ddr clock-to-data phase, 1 = 90 deg
  localparam int          BIT_SWING     = 13;         // output swing, 1 = higher
  localparam int          BIT_TP        = 8;          // test pattern mode enable
  localparam int          BIT_TWOS      = 4;          // 1 = two's complement
  localparam int          BIT_SDR_EDGE  = 2;          // 1 = sdr data on rising edge
  localparam int          SYNC_N        = 7;          // number of synchronised pins
  localparam int          PIN_PHASE     = 0;          // index of ddr_phase_pin
  localparam int          PIN_DEMUX     = 1;          // index of demux_select_pin
  localparam int          PIN_DDR       = 2;          // index of ddr mode pin
  localparam int          PIN_ECM       = 3;          // index of extended_control_mode pin
  localparam int          PIN_PD_I      = 4;          // index of i power-down pin
  localparam int          PIN_PD_Q      = 5;          // index of q power-down pin
  localparam int          PIN_DES       = 6;          // index of dual_edge_sampling pin
  localparam int          WORD_DIV_DEF  = 2;          // ref clocks per non-demux word
  localparam int          CNT_W         = 8;          // word period counter width
  localparam logic [2:0]  TP_LAST       = 3'h4;       // last index of the 5-word cycle
  localparam logic [11:0] TP_LOW_Q      = 12'h008;    // low pattern word, q ports
  localparam logic [11:0] TP_LOW_I      = 12'h010;    // low pattern word, i ports
  localparam logic [11:0] TP_HIGH_Q     = 12'hFF7;    // high pattern word, q ports
  localparam logic [11:0] TP_HIGH_I     = 12'hFEF;    // high pattern word, i ports
endpackage

// >>> adcof_tp_if.sv
// Purpose: carrier between the formatter top and the pattern generator
// Assumes: single clock domain, generator answers combinationally
// Notes:   words are valid in the same cycle as advance
`timescale 1ns/1ps
`default_nettype none
interface adcof_tp_if;
  logic        restart;   // test mode just entered
  logic        advance;   // one output word period begins
  logic        demux;     // demux pattern table selected
  logic [11:0] word_qd;   // pattern for q delayed bus
  logic [11:0] word_id;   // pattern for i delayed bus
  logic [11:0] word_q;    // pattern for q bus
  logic [11:0] word_i;    // pattern for i bus
  logic        or_q;      // pattern for overrange_q
  logic        or_i;      // pattern for overrange_i
  modport gen  (input restart, advance, demux, output word_qd, word_id, word_q, word_i, or_q, or_i);
  modport user (output restart, advance, demux, input word_qd, word_id, word_q, word_i, or_q, or_i);
endinterface
`default_nettype wire

// >>> adcof_tp_gen.sv
// Purpose: five-word test pattern sequencer
// Assumes: advance pulses once per output word period
// Notes:   same table whether or not dual edge sampling is on
`timescale 1ns/1ps
`default_nettype none
module adcof_tp_gen (
  input  wire logic  ref_clk_in,   // block clock
  input  wire logic  rst_n_in,     // async reset, active low
  input  wire logic  ce_in,        // clock enable
  adcof_tp_if.gen    tp            // pattern carrier
);
  import adcof_pkg::*;

  logic [2:0] idx_reg;    // index of the next word
  logic [2:0] idx_next;   // next index
  logic [2:0] cur;        // index of the word on offer
  logic       high_nd;    // non-demux high word
  logic       dm_hi_d;    // demux: delayed buses high
  logic       dm_hi_n;    // demux: plain buses high

  // restart forces the first word of the cycle
  assign cur      = tp.restart ? 3'h0 : idx_reg;
  // wrap after the fifth word
  assign idx_next = (cur == TP_LAST) ? 3'h0 : cur + 3'h1;
  assign high_nd  = cur[0];
  assign dm_hi_d  = (cur < 3'h2);
  assign dm_hi_n  = (cur == 3'h2) || (cur == 3'h3);

  // each channel its own word or its complement, on both of its ports in demux, delayed ports zero otherwise
  assign tp.word_qd = !tp.demux ? 12'h000 : (dm_hi_d ? TP_HIGH_Q : TP_LOW_Q);
  assign tp.word_id = !tp.demux ? 12'h000 : (dm_hi_d ? TP_HIGH_I : TP_LOW_I);
  assign tp.word_q  = (tp.demux ? dm_hi_n : high_nd) ? TP_HIGH_Q : TP_LOW_Q;
  assign tp.word_i  = (tp.demux ? dm_hi_n : high_nd) ? TP_HIGH_I : TP_LOW_I;
  // overrange high except on the all-low words
  assign tp.or_q    = tp.demux ? (cur != TP_LAST) : high_nd;
  assign tp.or_i    = tp.or_q;

  // index steps once per word period
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      idx_reg <= 3'h0;
    end else if (ce_in) begin
      if (tp.advance) begin
        idx_reg <= idx_next;
      end else if (tp.restart) begin
        idx_reg <= 3'h0;
      end
    end
  end
endmodule
`default_nettype wire

// >>> adcof_top_chk.sv
// Purpose: port checker for the output formatter top
// Assumes: ce_in held high, WORD_DIV of 2 or more
// Notes:   pin-based checks wait for 5 settled cycles
`timescale 1ns/1ps
`default_nettype none
module adcof_chk (
  input wire logic                         ref_clk_in,
  input wire logic                         rst_n_in,
  input wire logic                         ce_in,
  input wire logic                         ddr_phase_pin_in,
  input wire logic                         demux_select_pin_in,
  input wire logic                         ddr_mode_pin_in,
  input wire logic                         ecm_pin_in,
  input wire logic                         cfg_wr_in,
  input wire logic [adcof_pkg::ADDR_W-1:0] cfg_addr_in,
  input wire logic [adcof_pkg::CFG_W-1:0]  cfg_wdata_in,
  input wire logic [adcof_pkg::DATA_W-1:0] conv_q_in,
  input wire logic [adcof_pkg::CFG_W-1:0]  cfg_rdata_out,
  input wire logic                         output_data_clock_out,
  input wire logic [adcof_pkg::DATA_W-1:0] q_delayed_bus_out,
  input wire logic [adcof_pkg::DATA_W-1:0] i_delayed_bus_out,
  input wire logic [adcof_pkg::DATA_W-1:0] q_bus_out,
  input wire logic [adcof_pkg::DATA_W-1:0] i_bus_out,
  input wire logic                         swing_high_out,
  input wire logic                         word_strobe_out
);
  import adcof_pkg::*;
  logic [CFG_W-1:0] shadow_reg;                                       // copy of config register
  wire  cfg_hit = ce_in && cfg_wr_in && (cfg_addr_in == CFG_ADDR);   // accepted write
  wire  dd_on   = ddr_mode_pin_in & ~demux_select_pin_in & ~ecm_pin_in; // ddr by pin
  wire  sdr_pin = (~ddr_mode_pin_in | demux_select_pin_in) & ~ecm_pin_in; // sdr rising
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  // shadow follows accepted writes
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      shadow_reg <= CFG_RESET;
    end else if (cfg_hit) begin
      shadow_reg <= cfg_wdata_in;
    end
  end
  property p_rd_other; cfg_addr_in != CFG_ADDR |=> cfg_rdata_out == 16'h0000; endproperty
  a_rd_other: assert property (p_rd_other) else $error("other address read not zero");
  property p_wr; cfg_hit ##1 (cfg_addr_in == CFG_ADDR && !cfg_wr_in) |=> cfg_rdata_out == $past(cfg_wdata_in, 2);
  endproperty
  a_wr: assert property (p_wr) else $error("config readback wrong");
  property p_swing; cfg_hit |-> ##2 swing_high_out == $past(cfg_wdata_in[BIT_SWING], 2); endproperty
  a_swing: assert property (p_swing) else $error("swing select not followed");
  property p_pulse; word_strobe_out |=> !word_strobe_out; endproperty
  a_pulse: assert property (p_pulse) else $error("strobe longer than one cycle");
  property p_launch; ($changed(q_bus_out) || $changed(i_bus_out) || $changed(q_delayed_bus_out)) |-> word_strobe_out;
  endproperty
  a_launch: assert property (p_launch) else $error("data changed off word boundary");
  property p_ddr0; (dd_on & ~ddr_phase_pin_in)[*5] ##0 word_strobe_out |-> $changed(output_data_clock_out);
  endproperty
  a_ddr0: assert property (p_ddr0) else $error("ddr clock not toggling with data");
  property p_ddr90; (dd_on & ddr_phase_pin_in)[*5] ##0 word_strobe_out |-> $stable(output_data_clock_out);
  endproperty
  a_ddr90: assert property (p_ddr90) else $error("ddr 90 clock moved with data");
  property p_sdr; sdr_pin[*5] ##0 word_strobe_out |-> output_data_clock_out; endproperty
  a_sdr: assert property (p_sdr) else $error("sdr data not on rising edge");
  property p_nd; (!demux_select_pin_in)[*5] ##0 word_strobe_out |-> q_delayed_bus_out == 12'h000
    && i_delayed_bus_out == 12'h000; endproperty
  a_nd: assert property (p_nd) else $error("delayed buses busy in non-demux");
  property p_fmt; word_strobe_out && !$past(shadow_reg[BIT_TP])
    |-> q_bus_out == ($past(conv_q_in) ^ {$past(shadow_reg[BIT_TWOS]), 11'h000}); endproperty
  a_fmt: assert property (p_fmt) else $error("output coding wrong");
endmodule
bind adcof_top adcof_chk chk_u (.*);
`default_nettype wire

// >>> adcof_rx_model.sv
// Purpose: receiver model capturing the source-synchronous output
// Assumes: link clock sampled by the block clock
// Notes:   counts link edges, keeps last captured q word
`timescale 1ns/1ps
`default_nettype none
module adcof_rx_model (
  input  wire logic                         ref_clk_in,
  input  wire logic                         rst_n_in,
  input  wire logic                         link_clk_in,
  input  wire logic [adcof_pkg::DATA_W-1:0] q_bus_in,
  output logic [15:0]                       edge_cnt_out,
  output logic [15:0]                       rise_cnt_out,
  output logic [adcof_pkg::DATA_W-1:0]      cap_q_out
);
  import adcof_pkg::*;
  logic clk_d_reg;                              // link clock one cycle back
  wire  seen = link_clk_in ^ clk_d_reg;         // link edge found
  // capture on every link edge, as a ddr receiver would
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      clk_d_reg <= 1'b0;
      edge_cnt_out <= 16'h0000;
      rise_cnt_out <= 16'h0000;
      cap_q_out <= 12'h000;
    end else begin
      clk_d_reg <= link_clk_in;
      if (seen) begin
        edge_cnt_out <= edge_cnt_out + 16'h0001;
        cap_q_out <= q_bus_in;
      end
      if (seen && link_clk_in) begin
        rise_cnt_out <= rise_cnt_out + 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

// >>> tb_adcof_top.sv
// Purpose: self-checking bench for the output formatter
// Assumes: WORD_DIV of 20 gives a 160 ns sdr link clock
// Notes:   expected words are literals, never design outputs
`timescale 1ns/1ps
`default_nettype none
module tb_adcof_top;
  import adcof_pkg::*;
  localparam int WD = 20;                                   // ref clocks per word
  logic ref_clk_in = 1'b0, rst_n_in = 1'b0, ce_in = 1'b1, ddr_phase_pin_in = 1'b0, des_pin_in = 1'b0;
  logic demux_select_pin_in = 1'b0, ddr_mode_pin_in = 1'b0, ecm_pin_in = 1'b0, cfg_wr_in = 1'b0;
  logic pd_i_pin_in = 1'b0, pd_q_pin_in = 1'b0, conv_or_q_in = 1'b0, conv_or_i_in = 1'b1;
  logic [ADDR_W-1:0] cfg_addr_in = 4'h0;                    // config address
  logic [CFG_W-1:0]  cfg_wdata_in = 16'h0000, cfg_rdata_out;
  logic [DATA_W-1:0] conv_qd_in = 12'h456, conv_id_in = 12'h789, conv_q_in = 12'h123, conv_i_in = 12'h8F0;
  logic [DATA_W-1:0] q_delayed_bus_out, i_delayed_bus_out, q_bus_out, i_bus_out, cap_q;
  logic output_data_clock_out, overrange_q_out, overrange_i_out, swing_high_out, word_strobe_out;
  logic des_active_out, odc_prev;
  logic [15:0] edges, rises;                                 // receiver edge counts
  int mismatches = 0, samples_checked = 0, gap;
  adcof_top #(.WORD_DIV(WD)) dut_u (.*);
  adcof_rx_model model_u (.ref_clk_in, .rst_n_in, .link_clk_in(output_data_clock_out), .q_bus_in(q_bus_out),
    .edge_cnt_out(edges), .rise_cnt_out(rises), .cap_q_out(cap_q));
  always #4 ref_clk_in = ~ref_clk_in;
  task automatic wrap_up;
    if (mismatches == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // wait for the next launched word, sampled once settled
  task automatic nxt;
    gap = 0;
    do begin
      odc_prev = output_data_clock_out;
      @(posedge ref_clk_in);
      #1;
      gap++;
    end while (word_strobe_out !== 1'b1);
  endtask
  task automatic wr_cfg(input logic [15:0] d, input logic [3:0] a);
    @(posedge ref_clk_in);
    cfg_wr_in <= 1'b1;
    cfg_addr_in <= a;
    cfg_wdata_in <= d;
    @(posedge ref_clk_in);
    cfg_wr_in <= 1'b0;
    cfg_addr_in <= CFG_ADDR;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
    @(posedge ref_clk_in);
    cfg_addr_in <= a;
    repeat (2) @(posedge ref_clk_in);
    #1 chk({16'h0000, cfg_rdata_out}, {16'h0000, exp});
  endtask
  // mode pins change, then settle through the synchroniser
  task automatic pins(input logic dd, ph, dm, ec);
    @(posedge ref_clk_in);
    ddr_mode_pin_in <= dd;
    ddr_phase_pin_in <= ph;
    demux_select_pin_in <= dm;
    ecm_pin_in <= ec;
    repeat (3) nxt();
  endtask
  task automatic t_reg;
    rd_chk(CFG_ADDR, CFG_RESET);
    wr_cfg(16'h6004, CFG_ADDR);
    wr_cfg(16'hFFFF, 4'h5);
    rd_chk(4'h5, 16'h0000);
    rd_chk(CFG_ADDR, 16'h6004);
    chk({31'h00000000, swing_high_out}, 32'h00000001);
    wr_cfg(16'h0000, CFG_ADDR);
  endtask
  task automatic t_fmt;
    nxt();
    nxt();
    chk({8'h00, q_bus_out, i_bus_out}, 32'h001238F0);
    chk(gap, WD);
    chk({30'h00000000, overrange_q_out, overrange_i_out}, 32'h00000001);
    wr_cfg(16'h0010, CFG_ADDR);
    repeat (2) nxt();
    chk({8'h00, q_bus_out, i_bus_out}, 32'h009230F0);
    pins(1'b0, 1'b0, 1'b1, 1'b0);
    chk({8'h00, q_delayed_bus_out, i_delayed_bus_out}, 32'h00C56F89);
    chk(gap, 2 * WD);
    wr_cfg(16'h0000, CFG_ADDR);
    pins(1'b0, 1'b0, 1'b0, 1'b0);
  endtask
  task automatic t_clk;
    int e, r;
    pins(1'b1, 1'b0, 1'b0, 1'b0);
    e = edges;
    repeat (8) nxt();
    chk(edges - e, 8);
    chk({31'h00000000, output_data_clock_out ^ odc_prev}, 32'h00000001);
    chk({20'h00000, cap_q}, 32'h00000123);
    pins(1'b0, 1'b0, 1'b0, 1'b0);
    e = edges;
    r = rises;
    repeat (8) nxt();
    chk(edges - e, 16);
    chk(rises - r, 8);
    pins(1'b1, 1'b0, 1'b1, 1'b0);
    repeat (4) begin
      nxt();
      chk({31'h00000000, output_data_clock_out}, 32'h00000001);
    end
    pins(1'b0, 1'b0, 1'b0, 1'b1);
    chk({31'h00000000, output_data_clock_out}, 32'h00000000);
    wr_cfg(16'h0004, CFG_ADDR);
    repeat (2) nxt();
    chk({31'h00000000, output_data_clock_out}, 32'h00000001);
    pins(1'b1, 1'b0, 1'b0, 1'b1);
    wr_cfg(16'h4000, CFG_ADDR);
    repeat (2) nxt();
    chk({31'h00000000, output_data_clock_out ^ odc_prev}, 32'h00000000);
    wr_cfg(16'h0000, CFG_ADDR);
    pins(1'b1, 1'b1, 1'b0, 1'b0);
    chk({31'h00000000, output_data_clock_out ^ odc_prev}, 32'h00000000);
  endtask
  // check n pattern words, the first one already on the buses
  task automatic run(input logic dm, pq, pi, input int n);
    int x;
    logic hm, ho;
    logic [11:0] eq, ei, eqd, eid;
    for (int w = 0; w < n; w++) begin
      if (w > 0) nxt();
      x = w % 5;
      hm = dm ? (x == 2 || x == 3) : x[0];
      ho = dm ? (x < 4) : x[0];
      eq = pq ? 12'h000 : (hm ? 12'hFF7 : 12'h008);
      ei = pi ? 12'h000 : (hm ? 12'hFEF : 12'h010);
      eqd = (pq || !dm) ? 12'h000 : ((x < 2) ? 12'hFF7 : 12'h008);
      eid = (pi || !dm) ? 12'h000 : ((x < 2) ? 12'hFEF : 12'h010);
      chk({overrange_q_out, overrange_i_out, 6'h00, q_bus_out, i_bus_out}, {ho & ~pq, ho & ~pi, 6'h00, eq, ei});
      chk({8'h00, q_delayed_bus_out, i_delayed_bus_out}, {8'h00, eqd, eid});
    end
  endtask
  task automatic t_pat(input logic dm);
    pins(1'b0, 1'b0, dm, 1'b0);
    wr_cfg(16'h0100, CFG_ADDR);
    do nxt(); while (i_bus_out === conv_i_in);
    run(dm, 1'b0, 1'b0, 7);
    wr_cfg(16'h0000, CFG_ADDR);
    repeat (2) nxt();
    @(posedge ref_clk_in);
    des_pin_in <= 1'b1;
    pd_q_pin_in <= ~dm;
    pd_i_pin_in <= dm;
    wr_cfg(16'h0100, CFG_ADDR);
    do nxt(); while (i_bus_out === conv_i_in);
    run(dm, ~dm, dm, 10);
    chk({31'h00000000, des_active_out}, 32'h00000001);
    wr_cfg(16'h0000, CFG_ADDR);
    des_pin_in <= 1'b0;
    pd_q_pin_in <= 1'b0;
    pd_i_pin_in <= 1'b0;
  endtask
  initial begin
    #200000;
    mismatches++;
    wrap_up();
  end
  initial begin
    repeat (10) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    t_reg();
    t_fmt();
    t_clk();
    t_pat(1'b0);
    t_pat(1'b1);
    wrap_up();
  end
endmodule
`default_nettype wire
